// file: design/cced_consts.vh
// Purpose: constants for the processor control and addressing decoder
// Assumes: included by bare name
// Notes: opcodes, field codes and clock costs
`ifndef CCED_CONSTS_VH
`define CCED_CONSTS_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define CCED_OP_CARRY_CLR 8'hF8
`define CCED_OP_CARRY_INV 8'hF5
`define CCED_OP_CARRY_SET 8'hF9
`define CCED_OP_DIR_CLR 8'hFC
`define CCED_OP_DIR_SET 8'hFD
`define CCED_OP_INT_CLR 8'hFA
`define CCED_OP_INT_SET 8'hFB
`define CCED_OP_STOP 8'hF4
`define CCED_OP_WAIT 8'h9B
`define CCED_OP_LOCK 8'hF0
`define CCED_OP_NOP 8'h90
// ----------------------------------------
// Fields
// ----------------------------------------
`define CCED_MOD_NODISP 2'h0
`define CCED_MOD_DISP8 2'h1
`define CCED_MOD_DISP16 2'h2
`define CCED_MOD_REG 2'h3
`define CCED_RM_DIRECT 3'h6
`define CCED_SEG_ES 2'h0
`define CCED_SEG_CS 2'h1
`define CCED_SEG_SS 2'h2
`define CCED_SEG_DS 2'h3
// ----------------------------------------
// Clock costs
// ----------------------------------------
`define CCED_CLK_SHORT 4'h2
`define CCED_CLK_NOP 4'h3
`define CCED_CLK_WAIT 4'h6
`define CCED_CLK_EA 4'h4
`define CCED_CLK_WORD 4'h4
// Reset values
`define CCED_RST_FLAG 1'b0
`endif

// file: design/cced_decoder.v
// Purpose: processor control opcodes and addressing byte decoder
// Assumes: one byte presented per clock cycle with i_byte_valid high, synchronous inputs
// Notes: byte source must hold opcode bytes while o_busy is high; addressing and displacement bytes are taken while it is high
//
// Summary of operation
// - carry clear, invert, set in two clocks
// - direction clear and set in two clocks
// - interrupt enable clear and set, two clocks
// - lock prefix locks next instruction, two clocks
// - word memory transfers add four clocks
// - mode 11 selects register operand
// - modes give zero, sign-extended or 16-bit displacement
// - register/memory code picks base and index sum
// - mode 00 code 110 uses direct address
// - displacement follows addressing byte before immediates
// - address computation costs four clocks
// - segment override prefix selects segment
// - register codes map per width bit
// - base pointer forms default to stack segment
// - string destination always uses extra segment
// - readable stepping identifier output
`timescale 1ns/1ps
`include "cced_consts.vh"
module cced_decoder #(
    parameter [7:0] STEP_ID = 8'h5A // Arbitrary neutral stepping value
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_resetn,
    // Instruction byte stream
    input wire i_byte_valid,
    input wire [7:0] i_byte,
    input wire i_has_modrm,    // Opcode just given is followed by addressing byte
    input wire i_width_word,   // Width bit of the current instruction
    input wire i_mem_xfers,    // Instruction makes a memory transfer
    input wire i_string_dest,  // Operand is a string destination via DI
    // Register file values
    input wire [15:0] i_bx,
    input wire [15:0] i_bp,
    input wire [15:0] i_si,
    input wire [15:0] i_di,
    // Wait input, low means continue
    input wire i_test_n,
    // Flag state
    output reg o_carry_ff,
    output reg o_dir_ff,
    output reg o_int_en_ff,
    output reg o_lock_ff,
    output reg o_halted_ff,
    // Decode results
    output reg o_busy_ff,
    output reg o_done_ff,
    output reg [3:0] o_clocks_ff,
    output reg o_reg_operand_ff,
    output reg [3:0] o_reg_sel_ff,      // {width, code}
    output reg [15:0] o_effective_location_ff,
    output reg [1:0] o_segment_ff,
    output reg [7:0] o_stepping_identifier_ff
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] ST_OPC = 3'd0;
    localparam [2:0] ST_MODRM = 3'd1;
    localparam [2:0] ST_DLO = 3'd2;
    localparam [2:0] ST_DHI = 3'd3;
    localparam [2:0] ST_EXEC = 3'd4;
    localparam [2:0] ST_WAIT = 3'd5;
    localparam [2:0] ST_STOP = 3'd6;

    reg [2:0] state_ff;         // Sequencer state
    reg [3:0] cnt_ff;           // Execution clocks counted so far
    reg [3:0] cost_ff;          // Clocks charged for current instruction
    reg [1:0] mod_ff;           // Captured mode field
    reg [2:0] rm_ff;            // Captured register/memory field
    reg [7:0] disp_lo_ff;       // Low displacement byte
    reg seg_ovr_ff;             // Override prefix seen
    reg [1:0] seg_ovr_sel_ff;   // Override segment
    reg lock_pend_ff;           // Lock prefix waiting for next instruction
    reg [7:0] opc_ff;           // Current opcode

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Base and index sum for a register/memory code
    function [15:0] ea_base;
        input [2:0] rm;
        input [15:0] bx, bp, si, di;
        begin
            case (rm)
                3'd0: ea_base = bx + si;
                3'd1: ea_base = bx + di;
                3'd2: ea_base = bp + si;
                3'd3: ea_base = bp + di;
                3'd4: ea_base = si;
                3'd5: ea_base = di;
                3'd6: ea_base = bp;
                default: ea_base = bx;
            endcase
        end
    endfunction

    // Default segment; base pointer forms use stack
    function [1:0] def_seg;
        input [1:0] md;
        input [2:0] rm;
        begin
            if (rm == 3'd2 || rm == 3'd3 || (rm == `CCED_RM_DIRECT && md != `CCED_MOD_NODISP)) begin
                def_seg = `CCED_SEG_SS;
            end else begin
                def_seg = `CCED_SEG_DS;
            end
        end
    endfunction

    // Memory cost with address time and word penalty
    function [3:0] mem_cost;
        input word;
        input xfer;
        begin
            mem_cost = `CCED_CLK_EA;
            if (word && xfer) begin
                mem_cost = mem_cost + `CCED_CLK_WORD;
            end
        end
    endfunction

    // Prefix bytes: lock or segment override
    function is_prefix;
        input [7:0] op;
        begin
            is_prefix = (op == `CCED_OP_LOCK) || ((op[7:5] == 3'b001) && (op[2:0] == 3'b110));
        end
    endfunction

    wire is_seg_prefix = (i_byte[7:5] == 3'b001) && (i_byte[2:0] == 3'b110);
    wire [15:0] disp_s8 = {{8{i_byte[7]}}, i_byte};

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Single process keeps flag effects and timing in one place
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= ST_OPC;
            cnt_ff <= 4'h0;
            cost_ff <= 4'h0;
            mod_ff <= 2'h0;
            rm_ff <= 3'h0;
            disp_lo_ff <= 8'h00;
            seg_ovr_ff <= 1'b0;
            seg_ovr_sel_ff <= 2'h0;
            lock_pend_ff <= 1'b0;
            opc_ff <= 8'h00;
            o_carry_ff <= `CCED_RST_FLAG;
            o_dir_ff <= `CCED_RST_FLAG;
            o_int_en_ff <= `CCED_RST_FLAG;
            o_lock_ff <= 1'b0;
            o_halted_ff <= 1'b0;
            o_busy_ff <= 1'b0;
            o_done_ff <= 1'b0;
            o_clocks_ff <= 4'h0;
            o_reg_operand_ff <= 1'b0;
            o_reg_sel_ff <= 4'h0;
            o_effective_location_ff <= 16'h0000;
            o_segment_ff <= `CCED_SEG_DS;
            o_stepping_identifier_ff <= 8'h00;
        end else begin
            o_stepping_identifier_ff <= STEP_ID;
            o_done_ff <= 1'b0;
            case (state_ff)
                // Opcode or prefix byte
                ST_OPC: begin
                    if (i_byte_valid) begin
                        opc_ff <= i_byte;
                        o_busy_ff <= 1'b1;
                        o_lock_ff <= lock_pend_ff;
                        if (is_seg_prefix) begin
                            seg_ovr_ff <= 1'b1;
                            seg_ovr_sel_ff <= i_byte[4:3];
                            cost_ff <= `CCED_CLK_SHORT;
                            state_ff <= ST_EXEC;
                        end else if (i_byte == `CCED_OP_LOCK) begin
                            lock_pend_ff <= 1'b1;
                            cost_ff <= `CCED_CLK_SHORT;
                            state_ff <= ST_EXEC;
                        end else if (i_byte == `CCED_OP_WAIT) begin
                            cost_ff <= `CCED_CLK_WAIT;
                            state_ff <= ST_WAIT;
                        end else if (i_byte == `CCED_OP_NOP) begin
                            cost_ff <= `CCED_CLK_NOP;
                            state_ff <= ST_EXEC;
                        end else if (i_has_modrm) begin
                            state_ff <= ST_MODRM;
                        end else begin
                            cost_ff <= `CCED_CLK_SHORT;
                            state_ff <= ST_EXEC;
                        end
                        cnt_ff <= 4'h1;
                    end
                end
                // Addressing byte
                ST_MODRM: begin
                    if (i_byte_valid) begin
                        mod_ff <= i_byte[7:6];
                        rm_ff <= i_byte[2:0];
                        o_reg_sel_ff <= {i_width_word, i_byte[5:3]};
                        if (i_byte[7:6] == `CCED_MOD_REG) begin
                            o_reg_operand_ff <= 1'b1;
                            o_reg_sel_ff <= {i_width_word, i_byte[2:0]};
                            cost_ff <= `CCED_CLK_SHORT;
                            state_ff <= ST_EXEC;
                        end else begin
                            o_reg_operand_ff <= 1'b0;
                            cost_ff <= mem_cost(i_width_word, i_mem_xfers);
                            // Displacement bytes come next, before immediates
                            if (i_byte[7:6] == `CCED_MOD_NODISP && i_byte[2:0] == `CCED_RM_DIRECT) begin
                                state_ff <= ST_DLO;
                            end else if (i_byte[7:6] == `CCED_MOD_NODISP) begin
                                o_effective_location_ff <= ea_base(i_byte[2:0], i_bx, i_bp, i_si, i_di);
                                state_ff <= ST_EXEC;
                            end else begin
                                state_ff <= ST_DLO;
                            end
                            if (i_string_dest) begin
                                o_segment_ff <= `CCED_SEG_ES;
                            end else if (seg_ovr_ff) begin
                                o_segment_ff <= seg_ovr_sel_ff;
                            end else begin
                                o_segment_ff <= def_seg(i_byte[7:6], i_byte[2:0]);
                            end
                        end
                        cnt_ff <= 4'h1;
                    end
                end
                // Low displacement byte
                ST_DLO: begin
                    if (i_byte_valid) begin
                        disp_lo_ff <= i_byte;
                        if (mod_ff == `CCED_MOD_DISP8) begin
                            o_effective_location_ff <= ea_base(rm_ff, i_bx, i_bp, i_si, i_di) + disp_s8;
                            state_ff <= ST_EXEC;
                        end else begin
                            state_ff <= ST_DHI;
                        end
                    end
                end
                // High displacement byte sits above the low one
                ST_DHI: begin
                    if (i_byte_valid) begin
                        if (mod_ff == `CCED_MOD_NODISP) begin
                            o_effective_location_ff <= {i_byte, disp_lo_ff};
                        end else begin
                            o_effective_location_ff <= ea_base(rm_ff, i_bx, i_bp, i_si, i_di) + {i_byte, disp_lo_ff};
                        end
                        state_ff <= ST_EXEC;
                    end
                end
                // Count out clocks; apply effect on the last one
                ST_EXEC: begin
                    if (cnt_ff >= cost_ff) begin
                        case (opc_ff)
                            `CCED_OP_CARRY_CLR: o_carry_ff <= 1'b0;
                            `CCED_OP_CARRY_INV: o_carry_ff <= ~o_carry_ff;
                            `CCED_OP_CARRY_SET: o_carry_ff <= 1'b1;
                            `CCED_OP_DIR_CLR: o_dir_ff <= 1'b0;
                            `CCED_OP_DIR_SET: o_dir_ff <= 1'b1;
                            `CCED_OP_INT_CLR: o_int_en_ff <= 1'b0;
                            `CCED_OP_INT_SET: o_int_en_ff <= 1'b1;
                            default: ;
                        endcase
                        o_clocks_ff <= cost_ff;
                        o_done_ff <= 1'b1;
                        // Prefixes keep override and lock for the next byte
                        if (!is_prefix(opc_ff)) begin
                            seg_ovr_ff <= 1'b0;
                            lock_pend_ff <= 1'b0;
                        end
                        if (opc_ff == `CCED_OP_STOP) begin
                            o_halted_ff <= 1'b1;
                            state_ff <= ST_STOP;
                        end else begin
                            o_busy_ff <= 1'b0;
                            state_ff <= ST_OPC;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                // Stall until the test input goes low
                ST_WAIT: begin
                    if (!i_test_n) begin
                        state_ff <= ST_EXEC;
                    end
                end
                // Halted: only reset leaves this state
                ST_STOP: begin
                    o_busy_ff <= 1'b1;
                end
                default: state_ff <= ST_OPC;
            endcase
        end
    end
endmodule // cced_decoder

// file: verif/cced_decoder_monitor.sv
// Purpose: port assertions for the control and addressing decoder
// Assumes: low busy marks the idle cycle that takes an opcode
// Notes: bound from the testbench top file
`timescale 1ns/1ps
module cced_decoder_monitor #(
    parameter [7:0] STEP_ID = 8'h5A // Arbitrary value, must match the design
) (
    // Clock, reset and byte stream
    input wire i_clk_sys,
    input wire i_resetn,
    input wire i_byte_valid,
    input wire [7:0] i_byte,
    input wire i_has_modrm,
    // Watched outputs
    input wire o_carry_ff,
    input wire o_dir_ff,
    input wire o_int_en_ff,
    input wire o_lock_ff,
    input wire o_halted_ff,
    input wire o_busy_ff,
    input wire o_done_ff,
    input wire [3:0] o_clocks_ff,
    input wire o_reg_operand_ff,
    input wire [7:0] o_stepping_identifier_ff
);
    // ------
    // Helpers
    // ------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // Opcode taken from idle with no addressing byte
    wire acc = i_byte_valid && !o_busy_ff && !o_halted_ff && !i_has_modrm;
    // ------
    // Properties
    // ------
    property p_short; acc && i_byte[7:4] == 4'hF && i_byte != 8'hF4
        |-> ##1 !o_done_ff [*2] ##1 (o_done_ff && o_clocks_ff == 4'h2); endproperty
    a_short: assert property (p_short) else $error("short opcode cost wrong");
    property p_nop; acc && i_byte == 8'h90 |-> ##1 !o_done_ff [*3] ##1 (o_done_ff && o_clocks_ff == 4'h3);
    endproperty
    a_nop: assert property (p_nop) else $error("no-op cost wrong");
    property p_carry; acc && i_byte[7:1] == 7'h7C |-> ##3 o_carry_ff == $past(i_byte[0], 3); endproperty
    a_carry: assert property (p_carry) else $error("carry not set or cleared");
    property p_cinv; acc && i_byte == 8'hF5 |-> ##3 o_carry_ff != $past(o_carry_ff, 3); endproperty
    a_cinv: assert property (p_cinv) else $error("carry not inverted");
    property p_dir; acc && i_byte[7:1] == 7'h7E |-> ##3 o_dir_ff == $past(i_byte[0], 3); endproperty
    a_dir: assert property (p_dir) else $error("direction flag wrong");
    property p_inten; acc && i_byte[7:1] == 7'h7D |-> ##3 o_int_en_ff == $past(i_byte[0], 3); endproperty
    a_inten: assert property (p_inten) else $error("interrupt enable wrong");
    property p_lock; acc && i_byte == 8'hF0 ##3 acc && i_byte == 8'h90 |=> o_lock_ff; endproperty
    a_lock: assert property (p_lock) else $error("lock not held on next opcode");
    property p_halt; acc && i_byte == 8'hF4 |-> ##3 o_halted_ff; endproperty
    a_halt: assert property (p_halt) else $error("stop did not halt");
    // Halted core stays busy so that no further byte is taken
    property p_stay; o_halted_ff |=> o_halted_ff && o_busy_ff; endproperty
    a_stay: assert property (p_stay) else $error("halt left or work accepted");
    property p_pulse; o_done_ff |=> !o_done_ff; endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
    property p_step; $past(i_resetn) |-> o_stepping_identifier_ff == STEP_ID; endproperty
    a_step: assert property (p_step) else $error("stepping value wrong");
    // Main scenarios reached
    c_word: cover property (o_done_ff && o_clocks_ff == 4'h8);
    c_reg: cover property (o_done_ff && o_reg_operand_ff);
    c_halt: cover property ($rose(o_halted_ff));
endmodule // cced_decoder_monitor

// file: verif/tb_cced_decoder.sv
// Purpose: self-checking bench for the control and addressing decoder
// Assumes: inputs change 1 ns after the rising edge
// Notes: table rows first, then lock, wait, stop and reset by hand
`timescale 1ns/1ps
module tb_cced_decoder;
    // ------
    // Signals
    // ------
    typedef struct packed {
        logic [7:0] pre; logic [1:0] md; logic [2:0] rm; logic w; logic sd;
        logic [15:0] disp; logic [15:0] ea; logic [1:0] seg; logic [3:0] clk;
    } cced_row_t;
    localparam [7:0] STEP_VAL = 8'h3C; // Arbitrary stepping value
    reg i_clk_sys = 0, i_resetn = 0, i_byte_valid = 0, i_has_modrm = 0;
    reg i_width_word = 0, i_mem_xfers = 0, i_string_dest = 0, i_test_n = 1;
    reg [7:0] i_byte = 8'h00;
    reg [15:0] i_bx = 16'h1000, i_bp = 16'h2000, i_si = 16'h0030, i_di = 16'h0004;
    wire o_carry_ff, o_dir_ff, o_int_en_ff, o_lock_ff, o_halted_ff, o_busy_ff, o_done_ff, o_reg_operand_ff;
    wire [3:0] o_clocks_ff, o_reg_sel_ff;
    wire [15:0] o_effective_location_ff;
    wire [1:0] o_segment_ff;
    wire [7:0] o_stepping_identifier_ff;
    integer bad_count = 0, num_checks = 0, k;
    cced_row_t r;
    // Rows: opcode, cost, then carry, direction and enable afterwards
    logic [14:0] ctl [9] = '{{8'hF9, 4'h2, 3'h4}, {8'hF5, 4'h2, 3'h0}, {8'hF5, 4'h2, 3'h4},
        {8'hF8, 4'h2, 3'h0}, {8'hFD, 4'h2, 3'h2}, {8'hFC, 4'h2, 3'h0}, {8'hFB, 4'h2, 3'h1},
        {8'hFA, 4'h2, 3'h0}, {8'h90, 4'h3, 3'h0}};
    // Rows: prefix, mode, code, word, string dest, disp, address, segment, cost
    cced_row_t am [10] = '{'{8'h00, 2'h0, 3'h0, 1'h0, 1'h0, 16'h0000, 16'h1030, 2'h3, 4'h4},
        '{8'h00, 2'h1, 3'h2, 1'h1, 1'h0, 16'h00FE, 16'h202E, 2'h2, 4'h8},
        '{8'h00, 2'h2, 3'h7, 1'h0, 1'h0, 16'h1234, 16'h2234, 2'h3, 4'h4},
        '{8'h00, 2'h0, 3'h6, 1'h0, 1'h0, 16'h5678, 16'h5678, 2'h3, 4'h4},
        '{8'h00, 2'h1, 3'h6, 1'h0, 1'h0, 16'h0080, 16'h1F80, 2'h2, 4'h4},
        '{8'h2E, 2'h1, 3'h5, 1'h0, 1'h1, 16'h0005, 16'h0009, 2'h0, 4'h4},
        '{8'h36, 2'h0, 3'h7, 1'h0, 1'h0, 16'h0000, 16'h1000, 2'h2, 4'h4},
        '{8'h26, 2'h0, 3'h1, 1'h0, 1'h0, 16'h0000, 16'h1004, 2'h0, 4'h4},
        '{8'h3E, 2'h0, 3'h3, 1'h0, 1'h0, 16'h0000, 16'h2004, 2'h3, 4'h4},
        '{8'h2E, 2'h0, 3'h4, 1'h0, 1'h0, 16'h0000, 16'h0030, 2'h1, 4'h4}};
    cced_decoder #(.STEP_ID(STEP_VAL)) DUT (.i_clk_sys, .i_resetn, .i_byte_valid, .i_byte, .i_has_modrm,
        .i_width_word, .i_mem_xfers, .i_string_dest, .i_bx, .i_bp, .i_si, .i_di, .i_test_n, .o_carry_ff,
        .o_dir_ff, .o_int_en_ff, .o_lock_ff, .o_halted_ff, .o_busy_ff, .o_done_ff, .o_clocks_ff,
        .o_reg_operand_ff, .o_reg_sel_ff, .o_effective_location_ff, .o_segment_ff, .o_stepping_identifier_ff);
    // 50 MHz clock
    always #10 i_clk_sys = ~i_clk_sys;
    // ------
    // Tasks
    // ------
    task chk(input [15:0] got, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
            end
        end
    endtask
    // Offers one byte; valid stays up so back-to-back bytes never toggle it
    task put(input [7:0] b);
        begin
            i_byte = b;
            i_byte_valid = 1;
            @(posedge i_clk_sys);
            #1;
        end
    endtask
    // Bounded wait for completion
    task wait_done(input integer lim);
        integer n;
        begin
            n = 0;
            i_byte_valid = 0;
            while (o_done_ff !== 1'b1 && n < lim) begin
                @(posedge i_clk_sys);
                #1;
                n = n + 1;
            end
            chk(o_done_ff, 1);
        end
    endtask
    task op(input [7:0] b, input [3:0] c);
        begin
            i_has_modrm = 0;
            put(b);
            i_byte_valid = 0;
            repeat (c) @(posedge i_clk_sys);
            #1;
            chk(o_done_ff, 1);
            chk(o_clocks_ff, c);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks=%0d mismatches=%0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    // ------
    // Sequence
    // ------
    initial begin
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk(o_stepping_identifier_ff, 0);
        i_resetn = 1;
        for (k = 0; k < 9; k = k + 1) begin
            op(ctl[k][14:7], ctl[k][6:3]);
            chk({o_carry_ff, o_dir_ff, o_int_en_ff}, ctl[k][2:0]);
        end
        chk(o_stepping_identifier_ff, STEP_VAL);
        for (k = 0; k < 10; k = k + 1) begin
            r = am[k];
            if (r.pre != 0) op(r.pre, 2);
            i_has_modrm = 1;
            put(8'h8B);
            i_width_word = r.w;
            i_mem_xfers = 1;
            i_string_dest = r.sd;
            put({r.md, 3'h0, r.rm});
            if (r.md == 1 || r.md == 2 || r.rm == 6) put(r.disp[7:0]);
            if (r.md == 2 || (r.md == 0 && r.rm == 6)) put(r.disp[15:8]);
            wait_done(20);
            chk(o_effective_location_ff, r.ea);
            chk(o_segment_ff, r.seg);
            chk(o_clocks_ff, r.clk);
            chk(o_reg_operand_ff, 0);
        end
        i_string_dest = 0;
        for (k = 0; k < 8; k = k + 1) begin
            put(8'h8B);
            i_width_word = k[0];
            put({2'h3, 3'h0, k[2:0]});
            wait_done(8);
            chk(o_reg_operand_ff, 1);
            chk(o_reg_sel_ff, {k[0], k[2:0]});
        end
        op(8'hF0, 2);
        put(8'h90);
        i_byte_valid = 0;
        chk(o_lock_ff, 1);
        repeat (3) @(posedge i_clk_sys);
        #1;
        put(8'h9B);
        i_byte_valid = 0;
        repeat (10) @(posedge i_clk_sys);
        #1;
        chk(o_busy_ff, 1);
        i_test_n = 0;
        repeat (7) @(posedge i_clk_sys);
        #1;
        chk(o_done_ff, 1);
        chk(o_clocks_ff, 6);
        i_test_n = 1;
        op(8'hFB, 2);
        op(8'hF4, 2);
        put(8'hF9);
        i_byte_valid = 0;
        repeat (4) @(posedge i_clk_sys);
        #1;
        chk({o_halted_ff, o_carry_ff}, 2'h2);
        i_resetn = 0;
        #1;
        chk({o_halted_ff, o_int_en_ff, o_segment_ff, o_stepping_identifier_ff}, 12'h300);
        @(posedge i_clk_sys);
        #1;
        i_resetn = 1;
        op(8'hF9, 2);
        chk({o_carry_ff, o_stepping_identifier_ff}, {1'h1, STEP_VAL});
        report_and_stop;
    end
    // Watchdog well beyond the few hundred cycles of the sequence
    initial begin
        #50000;
        bad_count = bad_count + 1;
        report_and_stop;
    end
endmodule // tb_cced_decoder
bind cced_decoder cced_decoder_monitor #(.STEP_ID(STEP_ID)) u_mon (.i_clk_sys, .i_resetn, .i_byte_valid,
    .i_byte, .i_has_modrm, .o_carry_ff, .o_dir_ff, .o_int_en_ff, .o_lock_ff, .o_halted_ff, .o_busy_ff,
    .o_done_ff, .o_clocks_ff, .o_reg_operand_ff, .o_stepping_identifier_ff);
